// ### tco_compare_output.sv
// Compare-output waveform control with control register and shared high-byte staging
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Staged high byte stays in temp register after a 16-bit write, reusable.
// - Nonzero channel A mode overrides normal port function on its pin, except mode one in PWM without top bit.
// - Nonzero channel B mode overrides normal port function on its pin, except mode one in any PWM mode.
// - Waveform reaches pin only when the pin direction bit selects output.
// - Mode zero disconnects output in every waveform mode.
// - Non-PWM: modes one, two, three toggle, clear, set on match.
// - PWM mode one: disconnected unless top bit set; then A toggles, B reserved.
// - Fast PWM mode two: clear on match, set at BOTTOM.
// - Fast PWM mode three: set on match, clear at BOTTOM.
// - Fast PWM modes two and three: match ignored when compare equals TOP, BOTTOM action still done.
// - Dual-slope mode two: clear on up-count match, set on down-count match.
// - Dual-slope mode three: set on up-count match, clear on down-count match.
// - 16-bit write: high byte to temp first, low write loads both at once.
// - 16-bit counter and capture read: low read copies high byte into temp same cycle.
module tco_compare_output
	import tco_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire tco_pkg::tco_bus_req_t busReq,
	output logic [tco_pkg::DATA_W-1:0] rdData,
	input wire logic [1:0] waveformModeHigh,
	input wire tco_pkg::tco_counter_t counterIn,
	output tco_pkg::tco_load_t counterLoad,
	output tco_pkg::tco_load_t captureLoad,
	input wire tco_pkg::tco_port_t portA,
	input wire tco_pkg::tco_port_t portB,
	output tco_pkg::tco_pin_t pinA,
	output tco_pkg::tco_pin_t pinB,
	output logic chan_a_compare_out,
	output logic chan_b_compare_out
);
	import tco_pkg::*;

	// Temp must cover exactly the upper half of every 16-bit register
	if (CNT_W != 2 * DATA_W) begin : g_width_check
		$error("counter width must be twice the bus width");
	end
	if (ADDR_W < 4) begin : g_addr_check
		$error("address too narrow for the register map");
	end

	typedef struct packed {
		logic [DATA_W-1:0] timer_control_a;
		logic [DATA_W-1:0] temp;
		logic [CNT_W-1:0] chan_a_compare_value;
		logic [CNT_W-1:0] chan_b_compare_value;
		logic ocA;
		logic ocB;
		logic [DATA_W-1:0] rdData;
		tco_load_t cntLoad;
		tco_load_t capLoad;
	} tco_state_t;

	tco_state_t state_reg;
	tco_state_t state_next;

	logic [3:0] waveform_mode_sel;
	logic waveform_mode_top_bit;
	logic [1:0] chan_a_output_mode;
	logic [1:0] chan_b_output_mode;
	tco_wave_class_t waveClass;
	logic connA;
	logic connB;

	assign chan_a_output_mode = state_reg.timer_control_a[MODE_A_HI:MODE_A_LO];
	assign chan_b_output_mode = state_reg.timer_control_a[MODE_B_HI:MODE_B_LO];
	assign waveform_mode_sel = {waveformModeHigh, state_reg.timer_control_a[WGM_LO_HI:WGM_LO_LO]};
	assign waveform_mode_top_bit = waveformModeHigh[1];

	// Mode 13 is reserved; it is treated as non-PWM so the pin still behaves sanely
	always_comb begin
		unique case (waveform_mode_sel)
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: waveClass = WF_DUAL;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: waveClass = WF_FAST;
			default: waveClass = WF_NON_PWM;
		endcase
	end

	// Pin override decision for one channel
	function automatic logic connected(input logic [1:0] om, input tco_wave_class_t wc, input logic isA,
			input logic topBit);
		logic c;
		c = (om != OM_OFF);
		if (wc != WF_NON_PWM && om == OM_TOGGLE) begin
			c = isA && topBit;
		end
		return c;
	endfunction

	// Next compare output level for one channel
	function automatic logic nextOc(input logic oc, input logic [1:0] om, input tco_wave_class_t wc,
			input logic conn, input logic match, input logic bottom, input logic down, input logic cmpIsTop);
		logic n;
		n = oc;
		// Disconnected channel keeps its level, so reconnecting shows no glitch
		if (conn) begin
			unique case (wc)
				WF_NON_PWM: begin
					if (match) begin
						n = (om == OM_TOGGLE) ? ~oc : (om == OM_SET);
					end
				end
				WF_FAST: begin
					if (om == OM_TOGGLE) begin
						if (match) begin
							n = ~oc;
						end
					end else if (match && !cmpIsTop) begin
						n = (om == OM_SET);
					end else if (bottom) begin
						n = (om == OM_CLEAR);
					end
				end
				default: begin
					if (match) begin
						if (om == OM_TOGGLE) begin
							n = ~oc;
						end else begin
							n = (om == OM_SET) ^ down;
						end
					end
				end
			endcase
		end
		return n;
	endfunction

	assign connA = connected(chan_a_output_mode, waveClass, 1'b1, waveform_mode_top_bit);
	assign connB = connected(chan_b_output_mode, waveClass, 1'b0, waveform_mode_top_bit);

	always_comb begin
		logic matchA;
		logic matchB;
		logic atBottom;
		// Events only count on a tick, so a stalled counter never fires a match
		matchA = counterIn.tick && (counterIn.value == state_reg.chan_a_compare_value);
		matchB = counterIn.tick && (counterIn.value == state_reg.chan_b_compare_value);
		atBottom = counterIn.tick && (counterIn.value == BOTTOM_VALUE);
		state_next = state_reg;
		state_next.cntLoad.load = 1'b0;
		state_next.capLoad.load = 1'b0;
		state_next.ocA = nextOc(state_reg.ocA, chan_a_output_mode, waveClass, connA, matchA, atBottom,
			counterIn.down, state_reg.chan_a_compare_value == counterIn.top);
		state_next.ocB = nextOc(state_reg.ocB, chan_b_output_mode, waveClass, connB, matchB, atBottom,
			counterIn.down, state_reg.chan_b_compare_value == counterIn.top);
		if (busReq.wrEn) begin
			// Temp is never cleared by a low-byte write, so one high byte serves many registers
			unique case (busReq.addr)
				OFS_CTRL_A: state_next.timer_control_a = busReq.wrData;
				OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: state_next.temp = busReq.wrData;
				OFS_CNT_L: begin
					state_next.cntLoad.load = 1'b1;
					state_next.cntLoad.data = {state_reg.temp, busReq.wrData};
				end
				OFS_CMPA_L: state_next.chan_a_compare_value = {state_reg.temp, busReq.wrData};
				OFS_CMPB_L: state_next.chan_b_compare_value = {state_reg.temp, busReq.wrData};
				OFS_CAP_L: begin
					state_next.capLoad.load = 1'b1;
					state_next.capLoad.data = {state_reg.temp, busReq.wrData};
				end
				default: begin
				end
			endcase
		end else if (busReq.rdEn) begin
			// Compare registers read their high byte directly; temp is left untouched
			unique case (busReq.addr)
				OFS_CTRL_A: state_next.rdData = state_reg.timer_control_a;
				OFS_CNT_L: begin
					state_next.rdData = counterIn.value[DATA_W-1:0];
					state_next.temp = counterIn.value[CNT_W-1:DATA_W];
				end
				OFS_CAP_L: begin
					state_next.rdData = counterIn.capture[DATA_W-1:0];
					state_next.temp = counterIn.capture[CNT_W-1:DATA_W];
				end
				OFS_CNT_H, OFS_CAP_H: state_next.rdData = state_reg.temp;
				OFS_CMPA_L: state_next.rdData = state_reg.chan_a_compare_value[DATA_W-1:0];
				OFS_CMPA_H: state_next.rdData = state_reg.chan_a_compare_value[CNT_W-1:DATA_W];
				OFS_CMPB_L: state_next.rdData = state_reg.chan_b_compare_value[DATA_W-1:0];
				OFS_CMPB_H: state_next.rdData = state_reg.chan_b_compare_value[CNT_W-1:DATA_W];
				default: state_next.rdData = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg.timer_control_a <= CTRL_A_RESET;
			state_reg.temp <= TEMP_RESET;
			state_reg.chan_a_compare_value <= CMP_RESET;
			state_reg.chan_b_compare_value <= CMP_RESET;
			state_reg.ocA <= 1'b0;
			state_reg.ocB <= 1'b0;
			state_reg.rdData <= UNMAPPED_READ;
			state_reg.cntLoad <= '0;
			state_reg.capLoad <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Read data holds until the next read strobe
	assign rdData = state_reg.rdData;
	assign counterLoad = state_reg.cntLoad;
	assign captureLoad = state_reg.capLoad;
	assign chan_a_compare_out = state_reg.ocA;
	assign chan_b_compare_out = state_reg.ocB;
	// Direction bit alone gates the driver, even when the waveform owns the pin
	assign pinA.pinOut = connA ? state_reg.ocA : portA.portOut;
	assign pinA.pinOe = portA.portDir;
	assign pinB.pinOut = connB ? state_reg.ocB : portB.portOut;
	assign pinB.pinOe = portB.portDir;
endmodule
`default_nettype wire

// ### tco_cpu_model.sv
// Byte-wide CPU model for the register bus
`timescale 1ns/1ns
`default_nettype none
module tco_cpu_model (
	input wire logic clk,
	input wire logic [tco_pkg::DATA_W-1:0] rdData,
	output tco_pkg::tco_bus_req_t busReq
);
	import tco_pkg::*;
	initial busReq = '0;
	// One access at a time, never nested, so the shared temp is never split
	task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		busReq <= '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
		@(posedge clk);
		busReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
		#1 q = rdData;
	endtask
	// High byte first, low byte commits both
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		logic [7:0] q;
		access(1'b1, lo + 4'h1, v[15:8], q);
		access(1'b1, lo, v[7:0], q);
	endtask
endmodule
`default_nettype wire

// ### tco_pkg.sv
// Package with register map, field layout and types for the compare-output block
package tco_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CNT_L = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CNT_H = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CMPA_L = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_CMPA_H = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CMPB_L = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_CMPB_H = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_CAP_L = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_CAP_H = 4'h8;

	// Control A field positions
	localparam int MODE_A_HI = 7;
	localparam int MODE_A_LO = 6;
	localparam int MODE_B_HI = 5;
	localparam int MODE_B_LO = 4;
	localparam int WGM_LO_HI = 1;
	localparam int WGM_LO_LO = 0;

	localparam logic [DATA_W-1:0] CTRL_A_RESET = 8'h00;
	localparam logic [DATA_W-1:0] TEMP_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] BOTTOM_VALUE = 16'h0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

	// Output mode field codes
	localparam logic [1:0] OM_OFF = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR = 2'h2;
	localparam logic [1:0] OM_SET = 2'h3;

	typedef enum logic [1:0] {
		WF_NON_PWM = 2'b00,
		WF_FAST = 2'b01,
		WF_DUAL = 2'b10
	} tco_wave_class_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} tco_bus_req_t;

	typedef struct packed {
		logic tick;
		logic down;
		logic [CNT_W-1:0] value;
		logic [CNT_W-1:0] top;
		logic [CNT_W-1:0] capture;
	} tco_counter_t;

	typedef struct packed {
		logic load;
		logic [CNT_W-1:0] data;
	} tco_load_t;

	typedef struct packed {
		logic portOut;
		logic portDir;
	} tco_port_t;

	typedef struct packed {
		logic pinOut;
		logic pinOe;
	} tco_pin_t;
endpackage

// ### tco_properties.sv
// Checker for pin override and waveform actions of the compare-output block
`timescale 1ns/1ns
`default_nettype none
module tco_properties (
	input wire logic clk,
	input wire logic reset_n,
	input wire tco_pkg::tco_bus_req_t busReq,
	input wire logic [1:0] waveformModeHigh,
	input wire tco_pkg::tco_counter_t counterIn,
	input wire tco_pkg::tco_port_t portB,
	input wire tco_pkg::tco_pin_t pinA,
	input wire tco_pkg::tco_pin_t pinB,
	input wire logic chan_a_compare_out
);
	import tco_pkg::*;
	logic [7:0] ctrl_reg;
	logic [7:0] temp_reg;
	logic [15:0] cmpA_reg;
	logic [3:0] wgm;
	logic nonPwm;
	logic fast;
	logic hit;
	assign wgm = {waveformModeHigh, ctrl_reg[1:0]};
	assign nonPwm = wgm inside {4'h0, 4'h4, 4'hc, 4'hd};
	assign fast = wgm inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
	assign hit = counterIn.tick && counterIn.value == cmpA_reg;
	// Shadow of control and compare A, rebuilt from bus traffic
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_A_RESET;
			temp_reg <= TEMP_RESET;
			cmpA_reg <= CMP_RESET;
		end else if (busReq.wrEn) begin
			case (busReq.addr)
				OFS_CTRL_A: ctrl_reg <= busReq.wrData;
				OFS_CMPA_L: cmpA_reg <= {temp_reg, busReq.wrData};
				OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: temp_reg <= busReq.wrData;
				default: ;
			endcase
		end else if (busReq.rdEn && busReq.addr == OFS_CNT_L) begin
			temp_reg <= counterIn.value[15:8];
		end else if (busReq.rdEn && busReq.addr == OFS_CAP_L) begin
			temp_reg <= counterIn.capture[15:8];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	pin_enable_a: assert property (pinB.pinOe == portB.portDir) else $error("pin enable wrong");
	port_when_off_a: assert property (ctrl_reg[5:4] == 2'h0 |-> pinB.pinOut == portB.portOut)
		else $error("mode zero not port");
	a_override_a: assert property (ctrl_reg[7:6] != 2'h0
		&& (nonPwm || ctrl_reg[7] || waveformModeHigh[1]) |-> pinA.pinOut == chan_a_compare_out)
		else $error("A not overriding");
	b_reserved_a: assert property (!nonPwm && ctrl_reg[5:4] == 2'h1 |-> pinB.pinOut == portB.portOut)
		else $error("B reserved connected");
	toggle_match_a: assert property (nonPwm && ctrl_reg[7:6] == 2'h1 && hit
		|=> chan_a_compare_out != $past(chan_a_compare_out)) else $error("no toggle");
	set_clear_a: assert property (nonPwm && ctrl_reg[7] && hit
		|=> chan_a_compare_out == $past(ctrl_reg[6])) else $error("bad set or clear");
	fast_bottom_a: assert property (fast && ctrl_reg[7] && counterIn.tick && counterIn.value == 16'h0000
		&& cmpA_reg != 16'h0000 |=> chan_a_compare_out == !$past(ctrl_reg[6])) else $error("bad bottom");
	top_ignored_a: assert property (fast && ctrl_reg[7] && hit && cmpA_reg == counterIn.top
		&& counterIn.value != 16'h0000 |=> $stable(chan_a_compare_out)) else $error("top match acted");
	dual_match_a: assert property (!nonPwm && !fast && ctrl_reg[7] && hit
		|=> chan_a_compare_out == ($past(ctrl_reg[6]) ^ $past(counterIn.down))) else $error("bad dual match");
endmodule
bind tco_compare_output tco_properties u_props (.clk(clk), .reset_n(reset_n), .busReq(busReq),
	.waveformModeHigh(waveformModeHigh), .counterIn(counterIn), .portB(portB), .pinA(pinA), .pinB(pinB),
	.chan_a_compare_out(chan_a_compare_out));
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the compare-output block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import tco_pkg::*;
	logic clk, reset_n, chanA, chanB, expA, expB;
	logic [1:0] waveformModeHigh;
	logic [3:0] w;
	logic [7:0] rdData, q, ctrl;
	logic [15:0] cmpA, cmpB;
	tco_bus_req_t busReq;
	tco_counter_t counterIn;
	tco_load_t counterLoad, captureLoad;
	tco_port_t portA, portB;
	tco_pin_t pinA, pinB;
	int seed, mismatches, checks;
	tco_compare_output u_dut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
		.waveformModeHigh(waveformModeHigh), .counterIn(counterIn), .counterLoad(counterLoad),
		.captureLoad(captureLoad), .portA(portA), .portB(portB), .pinA(pinA), .pinB(pinB),
		.chan_a_compare_out(chanA), .chan_b_compare_out(chanB));
	tco_cpu_model u_cpu (.clk(clk), .rdData(rdData), .busReq(busReq));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic conn(input logic [1:0] m, input logic isA, input logic [3:0] wm);
		return m != 2'h0 && !(m == 2'h1 && !(wm inside {0, 4, 12, 13}) && !(isA && wm[3]));
	endfunction
	function automatic logic nxt(input logic oc, input logic [1:0] m, input logic isA, input logic [15:0] cmp);
		logic match;
		logic bottom;
		match = counterIn.tick && counterIn.value == cmp;
		bottom = counterIn.tick && counterIn.value == BOTTOM_VALUE;
		if (!conn(m, isA, w)) return oc;
		if (m == 2'h1) return match ? !oc : oc;
		if (w inside {0, 4, 12, 13}) return match ? m[0] : oc;
		if (w inside {5, 6, 7, 14, 15}) return (match && cmp != counterIn.top) ? m[0] : (bottom ? !m[0] : oc);
		return match ? m[0] ^ counterIn.down : oc;
	endfunction
	initial begin
		repeat (10000) @(posedge clk);
		mismatches++;
		end_sim();
	end
	initial begin
		seed = 17092;
		mismatches = 0;
		checks = 0;
		reset_n = 1'b0;
		waveformModeHigh = 2'h0;
		counterIn = '0;
		portA = '0;
		portB = '0;
		expA = 1'b0;
		expB = 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		u_cpu.access(1'b0, OFS_CTRL_A, 8'h00, q);
		chk(q, CTRL_A_RESET);
		u_cpu.access(1'b0, 4'hf, 8'h00, q);
		chk(q, UNMAPPED_READ);
		u_cpu.wr16(OFS_CMPA_L, 16'h01ff);
		u_cpu.access(1'b1, OFS_CMPB_L, 8'h22, q);
		u_cpu.access(1'b0, OFS_CMPB_H, 8'h00, q);
		chk(q, 8'h01);
		u_cpu.wr16(OFS_CNT_L, 16'h5aa5);
		chk(counterLoad.load, 1'b1);
		chk(counterLoad.data, 16'h5aa5);
		@(posedge clk) counterIn.value <= 16'h3c4d;
		u_cpu.access(1'b0, OFS_CNT_L, 8'h00, q);
		chk(q, 8'h4d);
		@(posedge clk) counterIn.value <= 16'h7788;
		u_cpu.access(1'b0, OFS_CNT_H, 8'h00, q);
		chk(q, 8'h3c);
		u_cpu.wr16(OFS_CAP_L, 16'h9c3e);
		chk(captureLoad.load, 1'b1);
		chk(captureLoad.data, 16'h9c3e);
		@(posedge clk) counterIn.capture <= 16'he17b;
		u_cpu.access(1'b0, OFS_CAP_L, 8'h00, q);
		chk(q, 8'h7b);
		@(posedge clk) counterIn.capture <= 16'h0000;
		u_cpu.access(1'b0, OFS_CAP_H, 8'h00, q);
		chk(q, 8'he1);
		u_cpu.access(1'b0, OFS_CMPA_H, 8'h00, q);
		chk(q, 8'h01);
		u_cpu.access(1'b0, OFS_CMPA_L, 8'h00, q);
		chk(q, 8'hff);
		$display("test registers done");
		for (int i = 0; i < 64; i++) begin
			ctrl = {i[1:0], 4'($random(seed)), i[3:2]};
			cmpA = 16'($random(seed)) & 16'h0003;
			cmpB = 16'($random(seed)) & 16'h0003;
			u_cpu.wr16(OFS_CMPA_L, cmpA);
			u_cpu.wr16(OFS_CMPB_L, cmpB);
			u_cpu.access(1'b1, OFS_CTRL_A, ctrl, q);
			@(posedge clk);
			waveformModeHigh <= i[5:4];
			counterIn.top <= i[0] ? 16'h0003 : 16'hffff;
			repeat (40) begin
				@(posedge clk);
				w = {waveformModeHigh, ctrl[1:0]};
				expA = nxt(expA, ctrl[7:6], 1'b1, cmpA);
				expB = nxt(expB, ctrl[5:4], 1'b0, cmpB);
				counterIn.tick <= 1'($random(seed));
				counterIn.down <= 1'($random(seed));
				counterIn.value <= 16'($random(seed)) & 16'h0003;
				portA <= 2'($random(seed));
				portB <= 2'($random(seed));
				#2;
				chk({chanA, chanB}, {expA, expB});
				chk(pinA.pinOut, conn(ctrl[7:6], 1'b1, w) ? expA : portA.portOut);
				chk(pinB.pinOut, conn(ctrl[5:4], 1'b0, w) ? expB : portB.portOut);
				chk({pinA.pinOe, pinB.pinOe}, {portA.portDir, portB.portDir});
			end
			// Model the edge that samples the last random step, then stop the timer
			@(posedge clk);
			expA = nxt(expA, ctrl[7:6], 1'b1, cmpA);
			expB = nxt(expB, ctrl[5:4], 1'b0, cmpB);
			counterIn.tick <= 1'b0;
		end
		$display("test waveform done");
		end_sim();
	end
endmodule
`default_nettype wire
